/* core/tpe_core.sv */
// Poisoned packet handling and error status registers with Wishbone slave
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`include "tpe_params.svh"

module tpe_core
(
   input  wire logic                CORE_CLK,
   input  wire logic                NRST,
   input  wire logic                WB_CYC_I,
   input  wire logic                WB_STB_I,
   input  wire logic                WB_WE_I,
   input  wire logic [5:0]          WB_ADR_I,
   input  wire logic [3:0]          WB_SEL_I,
   input  wire logic [31:0]         WB_DAT_I,
   output logic      [31:0]         WB_DAT_O,
   output logic                     WB_ACK_O,
   input  wire logic                RX_VALID,
   input  wire tpe_pkg::tpe_pkt_t   RX_KIND,
   input  wire logic                RX_POISON,
   input  wire logic                RX_MALFORMED,
   input  wire logic [31:0]         RX_DATA,
   output logic                     APP_RX_VALID,
   output logic                     APP_RX_POISON,
   output logic      [31:0]         APP_RX_DATA,
   input  wire logic                APP_TX_VALID,
   input  wire tpe_pkg::tpe_pkt_t   APP_TX_KIND,
   input  wire logic                APP_TX_POISON,
   input  wire logic [31:0]         APP_TX_DATA,
   output logic                     LINK_TX_VALID,
   output logic                     LINK_TX_POISON,
   output logic      [31:0]         LINK_TX_DATA,
   output logic                     CFG_CPL_VALID,
   output logic                     CFG_CPL_POISON,
   input  wire logic [31:0]         UNCOR_ERR_EVT,
   input  wire logic [31:0]         COR_ERR_EVT,
   output logic                     IRQ
);

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic                rst_meta_ff;
   logic                rst_n_ff;

   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         rst_meta_ff <= 1'b0;
         rst_n_ff    <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_n_ff    <= rst_meta_ff;
      end
   end

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   logic                bus_req;
   logic                wr_stb;
   logic [3:0]          idx;
   logic [31:0]         wmask;
   logic [31:0]         wdat;

   assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   // Writes land at the edge where the master samples ack high
   assign wr_stb  = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O;
   assign idx     = WB_ADR_I[5:2];
   assign wmask   = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
   assign wdat    = WB_DAT_I & wmask;

   // ------------------------------------------------------------
   // Control and configuration register
   // ------------------------------------------------------------
   logic                par_en_ff;
   logic [31:0]         cfg_reg_ff;
   logic                cfg_wr_ok;

   always_ff @(posedge CORE_CLK or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         par_en_ff <= 1'b0;
      else if (wr_stb && idx == `TPE_ADR_CTRL && WB_SEL_I[0])
         par_en_ff <= WB_DAT_I[`TPE_CTRL_PAR_EN];
   end

   // Only clean configuration writes land in the register
   assign cfg_wr_ok = RX_VALID & ~RX_MALFORMED & ~RX_POISON
                      & (RX_KIND == tpe_pkg::TPE_PKT_CFG_WR);

   always_ff @(posedge CORE_CLK or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         cfg_reg_ff <= `TPE_RST_WORD;
      else if (cfg_wr_ok)
         cfg_reg_ff <= RX_DATA;
   end

   // ------------------------------------------------------------
   // Receive path
   // ------------------------------------------------------------
   logic                rx_good;
   logic                rx_poison_evt;
   logic                rx_cpl_poison_evt;

   assign rx_good           = RX_VALID & ~RX_MALFORMED;
   assign rx_poison_evt     = rx_good & RX_POISON;
   assign rx_cpl_poison_evt = rx_poison_evt & (RX_KIND == tpe_pkg::TPE_PKT_CPL);

   always_ff @(posedge CORE_CLK or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         APP_RX_VALID  <= 1'b0;
         APP_RX_POISON <= 1'b0;
         APP_RX_DATA   <= `TPE_RST_WORD;
      end
      else
      begin
         APP_RX_VALID  <= rx_good;
         APP_RX_POISON <= rx_good & RX_POISON;
         APP_RX_DATA   <= RX_DATA;
      end
   end

   // ------------------------------------------------------------
   // Transmit path
   // ------------------------------------------------------------
   logic                tx_wr_poison_evt;

   assign tx_wr_poison_evt = APP_TX_VALID & APP_TX_POISON
                             & (APP_TX_KIND == tpe_pkg::TPE_PKT_MEM_WR);

   always_ff @(posedge CORE_CLK or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         LINK_TX_VALID  <= 1'b0;
         LINK_TX_POISON <= 1'b0;
         LINK_TX_DATA   <= `TPE_RST_WORD;
      end
      else
      begin
         LINK_TX_VALID  <= APP_TX_VALID;
         LINK_TX_POISON <= APP_TX_VALID & APP_TX_POISON;
         LINK_TX_DATA   <= APP_TX_DATA;
      end
   end

   // Configuration completion for every received configuration write that is not malformed
   always_ff @(posedge CORE_CLK or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         CFG_CPL_VALID  <= 1'b0;
         CFG_CPL_POISON <= 1'b0;
      end
      else
      begin
         CFG_CPL_VALID  <= rx_good & (RX_KIND == tpe_pkg::TPE_PKT_CFG_WR);
         CFG_CPL_POISON <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Sticky status registers
   // ------------------------------------------------------------
   logic                dpe_ff;
   logic                mdpe_ff;
   logic [31:0]         uncor_ff;
   logic [31:0]         cor_ff;
   logic [31:0]         clr_pstat;
   logic                mdpe_set;

   assign clr_pstat = (wr_stb && idx == `TPE_ADR_PSTAT) ? wdat : 32'h00000000;
   assign mdpe_set  = par_en_ff & (tx_wr_poison_evt | rx_cpl_poison_evt);

   always_ff @(posedge CORE_CLK or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         dpe_ff  <= 1'b0;
         mdpe_ff <= 1'b0;
      end
      else
      begin
         dpe_ff  <= rx_poison_evt | (dpe_ff & ~clr_pstat[`TPE_PSTAT_DPE]);
         mdpe_ff <= mdpe_set | (mdpe_ff & ~clr_pstat[`TPE_PSTAT_MDPE]);
      end
   end

   always_ff @(posedge CORE_CLK or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         uncor_ff <= `TPE_RST_WORD;
      else if (wr_stb && idx == `TPE_ADR_UNCOR)
         uncor_ff <= UNCOR_ERR_EVT | (uncor_ff & ~wdat);
      else
         uncor_ff <= UNCOR_ERR_EVT | uncor_ff;
   end

   always_ff @(posedge CORE_CLK or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         cor_ff <= `TPE_RST_WORD;
      else if (wr_stb && idx == `TPE_ADR_COR)
         cor_ff <= COR_ERR_EVT | (cor_ff & ~wdat);
      else
         cor_ff <= COR_ERR_EVT | cor_ff;
   end

   // ------------------------------------------------------------
   // Interrupt status and mask
   // ------------------------------------------------------------
   logic [`TPE_IRQ_W-1:0] ist_ff;
   logic [`TPE_IRQ_W-1:0] imask_ff;
   logic [`TPE_IRQ_W-1:0] ievt;
   logic [`TPE_IRQ_W-1:0] iclr;

   assign ievt = {|COR_ERR_EVT, |UNCOR_ERR_EVT, mdpe_set, rx_poison_evt};
   assign iclr = (wr_stb && idx == `TPE_ADR_ISTAT) ? wdat[`TPE_IRQ_W-1:0]
                                                   : {`TPE_IRQ_W{1'b0}};

   always_ff @(posedge CORE_CLK or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         ist_ff <= {`TPE_IRQ_W{1'b0}};
      else
         ist_ff <= ievt | (ist_ff & ~iclr);
   end

   always_ff @(posedge CORE_CLK or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         imask_ff <= {`TPE_IRQ_W{1'b0}};
      else if (wr_stb && idx == `TPE_ADR_IMASK && WB_SEL_I[0])
         imask_ff <= WB_DAT_I[`TPE_IRQ_W-1:0];
   end

   always_ff @(posedge CORE_CLK or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         IRQ <= 1'b0;
      else
         IRQ <= |((ievt | (ist_ff & ~iclr)) & imask_ff);
   end

   // ------------------------------------------------------------
   // Read mux and acknowledge
   // ------------------------------------------------------------
   logic [31:0]         rdat;

   always_comb
   begin
      case (idx)
         `TPE_ADR_CTRL   : rdat = {31'h00000000, par_en_ff};
         `TPE_ADR_PSTAT  : rdat = {16'h0000, dpe_ff, 6'h00, mdpe_ff, 8'h00};
         `TPE_ADR_UNCOR  : rdat = uncor_ff;
         `TPE_ADR_COR    : rdat = cor_ff;
         `TPE_ADR_ISTAT  : rdat = {28'h0000000, ist_ff};
         `TPE_ADR_IMASK  : rdat = {28'h0000000, imask_ff};
         `TPE_ADR_CFGREG : rdat = cfg_reg_ff;
         default         : rdat = 32'h00000000;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
      end
      else
      begin
         WB_ACK_O <= bus_req;
         WB_DAT_O <= bus_req ? rdat : 32'h00000000;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_rx_poison;
      RX_VALID && !RX_MALFORMED && RX_POISON;
   endsequence

   chk_rx_poison_fwd: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
      s_rx_poison |=> APP_RX_VALID && APP_RX_POISON)
      else $error("poisoned packet not forwarded");
   chk_malformed_drop: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
      RX_VALID && RX_MALFORMED |=> !APP_RX_VALID)
      else $error("malformed packet forwarded");
   chk_cfg_poison_hold: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
      s_rx_poison |=> $stable(cfg_reg_ff))
      else $error("poisoned config write changed register");
   chk_cfg_cpl_clean: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
      rx_good && RX_KIND == tpe_pkg::TPE_PKT_CFG_WR |=> CFG_CPL_VALID && !CFG_CPL_POISON)
      else $error("config completion poisoned");
   chk_dpe_set: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
      s_rx_poison |=> dpe_ff)
      else $error("detected parity flag not set");
   chk_mdpe_tx: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
      par_en_ff && tx_wr_poison_evt |=> mdpe_ff)
      else $error("master parity flag not set on tx");
   chk_mdpe_rx_cpl: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
      par_en_ff && rx_cpl_poison_evt |=> mdpe_ff)
      else $error("master parity flag not set on cpl");
   chk_mdpe_no_en: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
      !par_en_ff && !mdpe_ff |=> !mdpe_ff)
      else $error("master parity flag set without enable");
   chk_tx_poison_pass: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
      APP_TX_VALID && APP_TX_POISON |=> LINK_TX_VALID && LINK_TX_POISON)
      else $error("tx poison not passed");
   chk_uncor_sticky: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
      !(wr_stb && idx == `TPE_ADR_UNCOR) |=> ((uncor_ff & $past(uncor_ff)) == $past(uncor_ff)))
      else $error("uncorrectable bit lost");
   chk_cor_set: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
      COR_ERR_EVT != 32'h00000000 |=> (cor_ff & $past(COR_ERR_EVT)) == $past(COR_ERR_EVT))
      else $error("correctable bit not set");
   chk_w1c_only: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
      wr_stb && idx == `TPE_ADR_COR
      |=> cor_ff == ($past(COR_ERR_EVT) | ($past(cor_ff) & ~$past(wdat))))
      else $error("w1c cleared wrong bits");
   chk_dpe_hold: assert property (@(posedge CORE_CLK) disable iff (!rst_n_ff)
      dpe_ff && !clr_pstat[`TPE_PSTAT_DPE] |=> dpe_ff)
      else $error("parity flag dropped");

endmodule : tpe_core

/* core/tpe_params.svh */
// Register offsets, field positions, reset values for poison/error status block
`ifndef TPE_PARAMS_SVH
`define TPE_PARAMS_SVH
`define TPE_ADR_CTRL      4'h0
`define TPE_ADR_PSTAT     4'h1
`define TPE_ADR_UNCOR     4'h2
`define TPE_ADR_COR       4'h3
`define TPE_ADR_ISTAT     4'h4
`define TPE_ADR_IMASK     4'h5
`define TPE_ADR_CFGREG    4'h6
`define TPE_CTRL_PAR_EN   0
`define TPE_PSTAT_MDPE    8
`define TPE_PSTAT_DPE     15
`define TPE_RST_WORD      32'h00000000
`define TPE_IRQ_W         4
`define TPE_IRQ_DPE       0
`define TPE_IRQ_MDPE      1
`define TPE_IRQ_UNCOR     2
`define TPE_IRQ_COR       3
`endif

/* core/tpe_pkg.sv */
// Types shared by the poison/error status block
package tpe_pkg;
   typedef enum logic [1:0]
   {
      TPE_PKT_MEM_WR,
      TPE_PKT_CPL,
      TPE_PKT_CFG_WR,
      TPE_PKT_OTHER
   } tpe_pkt_t;
endpackage : tpe_pkg

/* sim/testbench.sv */
// Self-checking bench for the poison and error status block
`timescale 1ns/10ps
`include "tpe_params.svh"

module testbench;
   logic clk, nrst, cyc, stb, we, ack, app_v, app_p, lnk_v, lnk_p, cpl_v, cpl_p, irq;
   logic [5:0]  adr;
   logic [31:0] wdat, rdat, app_d, lnk_d, uevt, cevt;
   logic rx_v, rx_p, rx_m, tx_v, tx_p;
   logic [31:0] rx_d, tx_d;
   tpe_pkg::tpe_pkt_t rx_k, tx_k;
   int errors, n_compared;

   tpe_core u_dut (.CORE_CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .RX_VALID(rx_v), .RX_KIND(rx_k), .RX_POISON(rx_p), .RX_MALFORMED(rx_m), .RX_DATA(rx_d),
      .APP_RX_VALID(app_v), .APP_RX_POISON(app_p), .APP_RX_DATA(app_d), .APP_TX_VALID(tx_v),
      .APP_TX_KIND(tx_k), .APP_TX_POISON(tx_p), .APP_TX_DATA(tx_d), .LINK_TX_VALID(lnk_v),
      .LINK_TX_POISON(lnk_p), .LINK_TX_DATA(lnk_d), .CFG_CPL_VALID(cpl_v),
      .CFG_CPL_POISON(cpl_p), .UNCOR_ERR_EVT(uevt), .COR_ERR_EVT(cevt), .IRQ(irq));

   tpe_link_model u_link (.clk(clk), .rx_valid(rx_v), .rx_kind(rx_k), .rx_poison(rx_p),
      .rx_malformed(rx_m), .rx_data(rx_d), .tx_valid(tx_v), .tx_kind(tx_k), .tx_poison(tx_p),
      .tx_data(tx_d));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ----------------------------------------
   // Comparison, verdict, bus and error event tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results

   task automatic wb(input logic w, input logic [3:0] idx, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= d;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20)
      begin
         errors++;
         results();
      end
   endtask : wb

   task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, idx, 32'h00000000, q);
      check($sformatf("reg %0d", idx), q, exp);
   endtask : rd

   task automatic wr(input logic [3:0] idx, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, idx, d, q);
   endtask : wr

   task automatic pulse(input logic [31:0] u, input logic [31:0] c);
      @(posedge clk);
      uevt <= u;
      cevt <= c;
      @(posedge clk);
      uevt <= 32'h00000000;
      cevt <= 32'h00000000;
   endtask : pulse

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {nrst, cyc, stb, we, errors, n_compared} = '0;
      adr = 6'h00;
      wdat = 32'h00000000;
      uevt = 32'h00000000;
      cevt = 32'h00000000;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 8; i++)
         rd(i[3:0], 32'h00000000);
      $display("reset values done");
      u_link.send(1'b0, tpe_pkg::TPE_PKT_MEM_WR, 1'b1, 1'b0, 32'hA5A5_0001);
      #1;
      check("app rx", {app_v, app_p, 30'h0}, 32'hC0000000);
      check("app data", app_d, 32'hA5A50001);
      rd(`TPE_ADR_PSTAT, 32'h00008000);
      wr(`TPE_ADR_CTRL, 32'h00000001);
      u_link.send(1'b0, tpe_pkg::TPE_PKT_CPL, 1'b1, 1'b0, 32'h0000_1234);
      rd(`TPE_ADR_PSTAT, 32'h00008100);
      wr(`TPE_ADR_PSTAT, 32'h00000100);
      rd(`TPE_ADR_PSTAT, 32'h00008000);
      wr(`TPE_ADR_PSTAT, 32'h00008000);
      u_link.send(1'b1, tpe_pkg::TPE_PKT_MEM_WR, 1'b1, 1'b0, 32'h5A5A_0002);
      #1;
      check("link tx", {lnk_v, lnk_p, 30'h0}, 32'hC0000000);
      check("link data", lnk_d, 32'h5A5A0002);
      rd(`TPE_ADR_PSTAT, 32'h00000100);
      wr(`TPE_ADR_PSTAT, 32'h00000100);
      u_link.send(1'b1, tpe_pkg::TPE_PKT_CPL, 1'b1, 1'b0, 32'h5A5A_0005);
      u_link.send(1'b0, tpe_pkg::TPE_PKT_MEM_WR, 1'b1, 1'b0, 32'h0000_0006);
      rd(`TPE_ADR_PSTAT, 32'h00008000);
      wr(`TPE_ADR_PSTAT, 32'h00008000);
      wr(`TPE_ADR_CTRL, 32'h00000000);
      u_link.send(1'b1, tpe_pkg::TPE_PKT_MEM_WR, 1'b1, 1'b0, 32'h5A5A_0003);
      u_link.send(1'b0, tpe_pkg::TPE_PKT_CPL, 1'b1, 1'b0, 32'h0000_0004);
      rd(`TPE_ADR_PSTAT, 32'h00008000);
      wr(`TPE_ADR_PSTAT, 32'h00008000);
      $display("poison status done");
      u_link.send(1'b0, tpe_pkg::TPE_PKT_CFG_WR, 1'b0, 1'b0, 32'hCAFE_0010);
      #1;
      check("cfg cpl", {cpl_v, cpl_p, 30'h0}, 32'h80000000);
      rd(`TPE_ADR_CFGREG, 32'hCAFE0010);
      u_link.send(1'b0, tpe_pkg::TPE_PKT_CFG_WR, 1'b1, 1'b0, 32'hBEEF_0020);
      #1;
      check("cfg cpl poison", {cpl_v, cpl_p, 30'h0}, 32'h80000000);
      rd(`TPE_ADR_CFGREG, 32'hCAFE0010);
      u_link.send(1'b0, tpe_pkg::TPE_PKT_MEM_WR, 1'b0, 1'b1, 32'h0000_0030);
      #1;
      check("malformed", {31'h0, app_v}, 32'h00000000);
      $display("config and malformed done");
      pulse(32'h00000011, 32'h00000041);
      pulse(32'h00000000, 32'h00000040);
      rd(`TPE_ADR_UNCOR, 32'h00000011);
      rd(`TPE_ADR_COR, 32'h00000041);
      wr(`TPE_ADR_UNCOR, 32'h00000001);
      wr(`TPE_ADR_COR, 32'h00000040);
      rd(`TPE_ADR_UNCOR, 32'h00000010);
      rd(`TPE_ADR_COR, 32'h00000001);
      $display("error status done");
      wr(`TPE_ADR_ISTAT, 32'h0000000F);
      rd(`TPE_ADR_ISTAT, 32'h00000000);
      check("irq clear", {31'h0, irq}, 32'h00000000);
      wr(`TPE_ADR_IMASK, 32'h00000000);
      pulse(32'h00000002, 32'h00000000);
      rd(`TPE_ADR_ISTAT, 32'h00000004);
      check("irq masked", {31'h0, irq}, 32'h00000000);
      wr(`TPE_ADR_IMASK, 32'h0000000F);
      rd(`TPE_ADR_IMASK, 32'h0000000F);
      check("irq raised", {31'h0, irq}, 32'h00000001);
      wr(`TPE_ADR_ISTAT, 32'h00000004);
      rd(`TPE_ADR_ISTAT, 32'h00000000);
      check("irq cleared", {31'h0, irq}, 32'h00000000);
      $display("interrupt done");
      results();
   end
endmodule : testbench

/* sim/tpe_link_model.sv */
// Link partner and application model that sends single-word packets
`timescale 1ns/10ps

module tpe_link_model
(
   input  wire logic        clk,
   output logic             rx_valid,
   output tpe_pkg::tpe_pkt_t rx_kind,
   output logic             rx_poison,
   output logic             rx_malformed,
   output logic [31:0]      rx_data,
   output logic             tx_valid,
   output tpe_pkg::tpe_pkt_t tx_kind,
   output logic             tx_poison,
   output logic [31:0]      tx_data
);
   initial
   begin
      rx_valid = 1'b0;
      rx_kind = tpe_pkg::TPE_PKT_OTHER;
      rx_poison = 1'b0;
      rx_malformed = 1'b0;
      rx_data = 32'h00000000;
      tx_valid = 1'b0;
      tx_kind = tpe_pkg::TPE_PKT_OTHER;
      tx_poison = 1'b0;
      tx_data = 32'h00000000;
   end

   // ----------------------------------------
   // One word from the link (app 0) or from the application (app 1)
   // ----------------------------------------
   task automatic send(input logic app, input tpe_pkg::tpe_pkt_t kind, input logic poison,
                       input logic bad, input logic [31:0] data);
      @(posedge clk);
      if (app)
      begin
         tx_valid <= 1'b1;
         tx_kind <= kind;
         tx_poison <= poison;
         tx_data <= data;
      end
      else
      begin
         rx_valid <= 1'b1;
         rx_kind <= kind;
         rx_poison <= poison;
         rx_malformed <= bad;
         rx_data <= data;
      end
      @(posedge clk);
      // Released data lines show the inverse so stale data cannot pass
      rx_valid <= 1'b0;
      tx_valid <= 1'b0;
      rx_data <= ~rx_data;
      tx_data <= ~tx_data;
   endtask : send
endmodule : tpe_link_model
